// >>> verilog/auf_core.sv
// Async framing core: 16x-clocked UART transmitter and receiver
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
module auf_core
  import auf_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Serial side
  input  wire logic              tx_bit_clock_16x_i,
  input  wire logic              rx_bit_clock_16x_i,
  input  wire logic              rx_serial_in_i,
  output logic                   tx_serial_out_o,
  // Host strobes and controls
  input  wire logic              tx_load_strobe_n_i,
  input  wire logic [7:0]        tx_word_i,
  input  wire logic              control_strobe_i,
  input  wire auf_pkg::auf_cfg_t cfg_i,
  input  wire logic              master_clear_i,
  input  wire logic              rx_ready_reset_n_i,
  input  wire logic              status_out_enable_n_i,
  input  wire logic              rx_word_out_enable_n_i,
  // Host outputs
  output logic                   tx_char_done_o,
  output logic [7:0]             rx_word_o,
  output logic                   rx_word_oe_o,
  output auf_pkg::auf_stat_t     status_o,
  output logic                   status_oe_o,
  // Register port and interrupt
  input  wire logic [3:0]        addr_i,
  input  wire logic [7:0]        wdata_i,
  input  wire logic              we_i,
  input  wire logic              re_i,
  output logic [7:0]             rdata_o,
  output logic                   irq_o
);

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pin_m;
  logic [PIN_W-1:0] pin_q;
  logic [2:0]       edge_d;
  logic             tcp_q, rcp_q, rsi_q, tds_q, cs_q, mc_q;
  logic             rdar_q, swe_q, rde_q;
  auf_cfg_t         cfg_in;
  auf_cfg_t         cfg_q;
  logic [7:0]       td_q;
  logic             tcp_fall, rcp_tick, tds_end;
  logic [3:0]       nbits;
  logic [7:0]       data_mask;
  logic [5:0]       stop_ticks;
  logic             par_en;

  auf_tx_st_t       tx_st;
  logic [5:0]       tx_cnt;
  logic [3:0]       tx_bits;
  logic [7:0]       tx_sh;
  logic [7:0]       tx_hold;
  logic [7:0]       tx_m;
  logic             tx_par, tx_par_now, tx_empty, tx_done, tx_last;

  auf_rx_st_t       rx_st;
  logic [5:0]       rx_cnt;
  logic [3:0]       rx_bits;
  logic [7:0]       rx_sh;
  logic [7:0]       rx_data;
  logic             rx_pbit, rsi_last, rx_done, perr_now, ferr_now;
  logic [7:0]       rx_word;
  logic             rx_ready, rx_over, rx_ferr, rx_perr;

  logic [3:0]       irq_stat;
  logic [3:0]       irq_en;
  logic [3:0]       irq_evt;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  assign pins = {tx_bit_clock_16x_i, rx_bit_clock_16x_i, rx_serial_in_i,
                 tx_load_strobe_n_i, control_strobe_i, master_clear_i,
                 rx_ready_reset_n_i, status_out_enable_n_i,
                 rx_word_out_enable_n_i, cfg_i, tx_word_i};
  assign {tcp_q, rcp_q, rsi_q, tds_q, cs_q, mc_q, rdar_q, swe_q, rde_q,
          cfg_in, td_q} = pin_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_m  <= PIN_RST;
      pin_q  <= PIN_RST;
      edge_d <= EDGE_RST;
    end else begin
      pin_m  <= pins;
      pin_q  <= pin_m;
      edge_d <= {tcp_q, rcp_q, tds_q};
    end
  end

  assign tcp_fall = edge_d[2] & ~tcp_q;
  assign rcp_tick = ~edge_d[1] & rcp_q;
  assign tds_end  = ~edge_d[0] & tds_q;

  // control loaded on every cycle while the strobe is high
  // Held high, the strobe keeps following the pins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= CFG_RST;
    end else if (cs_q) begin
      cfg_q <= cfg_in;
    end
  end

  assign nbits     = MIN_DATA_BITS + {2'b00, cfg_q.char_length_sel_hi,
                                      cfg_q.char_length_sel_lo};
  assign data_mask = 8'hff >> (MAX_DATA_BITS - nbits);
  assign par_en    = ~cfg_q.parity_disable;
  assign stop_ticks = !cfg_q.stop_bits_select ? STOP_1_TICKS :
                      (nbits == MIN_DATA_BITS) ? STOP_15_TICKS : STOP_2_TICKS;

  //////////////////////////////////////////////////////////////////////////////
  // Transmitter
  assign tx_m       = tx_hold & data_mask;
  assign tx_par_now = cfg_q.parity_even_select ? ^tx_m : ~^tx_m;
  assign tx_last    = (tx_st == TX_IDLE) ||
                      (tx_st == TX_STOP && tx_cnt == stop_ticks - 6'h01);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_st           <= TX_IDLE;
      tx_cnt          <= 6'h00;
      tx_bits         <= 4'h0;
      tx_sh           <= 8'h00;
      tx_hold         <= 8'h00;
      tx_par          <= 1'b0;
      tx_empty        <= 1'b1;
      tx_done         <= 1'b1;
      tx_serial_out_o <= 1'b1;
    end else if (mc_q) begin
      tx_st           <= TX_IDLE;
      tx_cnt          <= 6'h00;
      tx_empty        <= 1'b1;
      tx_done         <= 1'b1;
      tx_serial_out_o <= 1'b1;
    end else begin
      if (tds_end) begin
        tx_hold  <= td_q;
        tx_empty <= 1'b0;
      end
      if (tcp_fall) begin
        tx_cnt <= tx_cnt + 6'h01;
        if (tx_last && !tx_empty) begin
          // start bit on transmit clock fall
          tx_st           <= TX_START;
          tx_sh           <= tx_m;
          tx_par          <= tx_par_now;
          tx_cnt          <= 6'h00;
          tx_bits         <= 4'h0;
          tx_empty        <= ~tds_end;
          tx_done         <= 1'b0;
          tx_serial_out_o <= 1'b0;
        end else if (tx_st == TX_STOP && tx_last) begin
          tx_st   <= TX_IDLE;
          tx_done <= 1'b1;
        end else if (tx_st != TX_STOP && tx_cnt == BIT_TICKS - 6'h01) begin
          tx_cnt <= 6'h00;
          unique case (tx_st)
            TX_START: begin
              tx_st           <= TX_DATA;
              tx_serial_out_o <= tx_sh[0];
            end
            TX_DATA: begin
              tx_bits <= tx_bits + 4'h1;
              tx_sh   <= tx_sh >> 1;
              if (tx_bits != nbits - 4'h1) begin
                tx_serial_out_o <= tx_sh[1];
              end else if (par_en) begin
                tx_st           <= TX_PAR;
                tx_serial_out_o <= tx_par;
              end else begin
                tx_st           <= TX_STOP;
                tx_serial_out_o <= 1'b1;
              end
            end
            TX_PAR: begin
              tx_st           <= TX_STOP;
              tx_serial_out_o <= 1'b1;
            end
            TX_IDLE, TX_STOP: begin
              tx_st <= TX_IDLE;
            end
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receiver framing
  assign rx_data  = rx_sh >> (MAX_DATA_BITS - nbits);
  assign rx_done  = rcp_tick && !mc_q && rx_st == RX_STOP &&
                    rx_cnt == BIT_TICKS - 6'h01;
  assign ferr_now = ~rsi_q;
  assign perr_now = par_en &&
    (rx_pbit != (cfg_q.parity_even_select ? ^rx_data : ~^rx_data));

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_st    <= RX_IDLE;
      rx_cnt   <= 6'h00;
      rx_bits  <= 4'h0;
      rx_sh    <= 8'h00;
      rx_pbit  <= 1'b0;
      rsi_last <= 1'b1;
    end else if (mc_q) begin
      rx_st    <= RX_IDLE;
      rsi_last <= 1'b1;
    end else if (rcp_tick) begin
      rsi_last <= rsi_q;
      rx_cnt   <= rx_cnt + 6'h01;
      unique case (rx_st)
        // fall seen on the next receive tick
        RX_IDLE: begin
          if (rsi_last && !rsi_q) begin
            rx_st  <= RX_VERIFY;
            rx_cnt <= 6'h01;
          end
        end
        // verified after half a bit low
        RX_VERIFY: begin
          if (rsi_q) begin
            rx_st <= RX_IDLE;
          end else if (rx_cnt == HALF_BIT_TICKS - 6'h01) begin
            rx_st   <= RX_DATA;
            rx_cnt  <= 6'h00;
            rx_bits <= 4'h0;
          end
        end
        default: begin
          // one sample per bit at centre
          if (rx_cnt == BIT_TICKS - 6'h01) begin
            rx_cnt <= 6'h00;
            if (rx_st == RX_DATA) begin
              rx_sh   <= {rsi_q, rx_sh[7:1]};
              rx_bits <= rx_bits + 4'h1;
              if (rx_bits == nbits - 4'h1) begin
                rx_st <= par_en ? RX_PAR : RX_STOP;
              end
            end else if (rx_st == RX_PAR) begin
              rx_pbit <= rsi_q;
              rx_st   <= RX_STOP;
            end else begin
              rx_st <= RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Receive buffer and flags; a new character beats the ready reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_word  <= 8'h00;
      rx_ready <= 1'b0;
      rx_over  <= 1'b0;
      rx_ferr  <= 1'b0;
      rx_perr  <= 1'b0;
    end else if (mc_q) begin
      rx_ready <= 1'b0;
      rx_over  <= 1'b0;
      rx_ferr  <= 1'b0;
      rx_perr  <= 1'b0;
    end else begin
      rx_ready <= rx_done | (rx_ready & rdar_q);
      if (rx_done) begin
        rx_over <= rx_ready;
        rx_word <= rx_data;
        rx_ferr <= ferr_now;
        rx_perr <= perr_now;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_word_o      <= 8'h00;
      rx_word_oe_o   <= 1'b0;
      status_o       <= STAT_RST;
      status_oe_o    <= 1'b0;
      tx_char_done_o <= 1'b1;
    end else begin
      rx_word_o      <= rx_word;
      rx_word_oe_o   <= ~rde_q;
      status_o       <= {rx_perr, rx_ferr, rx_over, rx_ready, tx_empty};
      status_oe_o    <= ~swe_q;
      tx_char_done_o <= tx_done;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt registers; a new event beats a clear
  assign irq_evt = {rx_done & perr_now, rx_done & ferr_now,
                    rx_done & rx_ready, rx_done};

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_stat <= 4'h0;
      irq_en   <= IRQ_EN_RST;
      irq_o    <= 1'b0;
      rdata_o  <= 8'h00;
    end else begin
      irq_stat <= irq_evt | (irq_stat &
                  ~((we_i && addr_i == REG_IRQ_CLR) ? wdata_i[3:0] : 4'h0));
      if (we_i && addr_i == REG_IRQ_EN) begin
        irq_en <= wdata_i[3:0];
      end
      irq_o   <= |(irq_stat & irq_en);
      rdata_o <= 8'h00;
      if (re_i && addr_i == REG_IRQ_STAT) begin
        rdata_o <= {4'h0, irq_stat};
      end else if (re_i && addr_i == REG_IRQ_EN) begin
        rdata_o <= {4'h0, irq_en};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_tx_start_edge: assert property (
    (tx_st == TX_IDLE && !tx_empty && tcp_fall && !mc_q)
      |=> (!tx_serial_out_o && tx_st == TX_START))
    else $error("start bit not sent on transmit clock fall");
  chk_tx_idle_load: assert property (
    (tds_end && tx_st == TX_IDLE && tx_empty && !mc_q) |=> !tx_empty)
    else $error("idle load not taken");
  chk_tx_bit_hold: assert property (
    (!tcp_fall && !mc_q) |=> $stable(tx_serial_out_o))
    else $error("serial out moved between ticks");
  chk_tx_data_lsb: assert property (
    (tx_st == TX_DATA) |-> (tx_serial_out_o == tx_sh[0]))
    else $error("data bit out of order");
  chk_rx_start_seen: assert property (
    (rx_st == RX_IDLE && rcp_tick && rsi_last && !rsi_q && !mc_q)
      |=> rx_st == RX_VERIFY)
    else $error("start fall missed");
  chk_rx_abort: assert property (
    (rx_st == RX_VERIFY && rcp_tick && rsi_q && !mc_q) |=> rx_st == RX_IDLE)
    else $error("false start not abandoned");
  chk_rx_verify_half: assert property (
    (rx_st == RX_DATA && $past(rx_st) == RX_VERIFY)
      |-> ($past(rx_cnt) == HALF_BIT_TICKS - 6'h01 && !$past(rsi_q)))
    else $error("start verified early");
  chk_overrun_set: assert property (
    (rx_done && rx_ready) |=> rx_over)
    else $error("overrun not raised");
  chk_overrun_clear: assert property (
    (rx_done && !rx_ready) |=> (!rx_over && rx_ready))
    else $error("overrun raised wrongly");
  chk_no_parity: assert property (
    (rx_done && cfg_q.parity_disable) |=> !rx_perr)
    else $error("parity error without parity");
  chk_master_clear: assert property (
    mc_q |=> (tx_serial_out_o && tx_done && tx_empty && !rx_ready && !rx_over))
    else $error("master clear incomplete");
  chk_word_float: assert property (
    rde_q |=> !rx_word_oe_o)
    else $error("data driven while disabled");
  chk_status_float: assert property (
    swe_q |=> !status_oe_o)
    else $error("status driven while disabled");

  cov_overrun: cover property (rx_done && rx_ready);
  cov_false_start: cover property (rx_st == RX_VERIFY && rcp_tick && rsi_q);
  cov_frame_err: cover property (rx_done && !rsi_q);
  cov_back_to_back: cover property (tx_st == TX_STOP && tcp_fall &&
                                    tx_last && !tx_empty);

endmodule

// >>> verilog/auf_pkg.sv
// Constants and carrier types of the async framing core
package auf_pkg;

  // Serial timing in 16x clock ticks; data bit counts
  localparam logic [5:0] BIT_TICKS      = 6'h10;
  localparam logic [5:0] HALF_BIT_TICKS = 6'h08;
  localparam logic [5:0] STOP_1_TICKS   = 6'h10;
  localparam logic [5:0] STOP_15_TICKS  = 6'h18;
  localparam logic [5:0] STOP_2_TICKS   = 6'h20;
  localparam logic [3:0] MIN_DATA_BITS  = 4'h5;
  localparam logic [3:0] MAX_DATA_BITS  = 4'h8;

  // Register port offsets and enable reset value
  localparam logic [3:0] REG_IRQ_STAT   = 4'h0;
  localparam logic [3:0] REG_IRQ_EN     = 4'h4;
  localparam logic [3:0] REG_IRQ_CLR    = 4'h8;
  localparam logic [3:0] IRQ_EN_RST     = 4'h0;

  // Synchroniser width and idle levels of the pins
  localparam int unsigned PIN_W         = 22;
  localparam logic [21:0] PIN_RST       = 22'h0ce000;
  localparam logic [2:0]  EDGE_RST      = 3'h1;

  typedef struct packed {
    logic char_length_sel_hi;
    logic char_length_sel_lo;
    logic stop_bits_select;
    logic parity_disable;
    logic parity_even_select;
  } auf_cfg_t;

  typedef struct packed {
    logic par_err;
    logic frm_err;
    logic rx_overrun_flag;
    logic rx_char_ready;
    logic tx_holding_empty;
  } auf_stat_t;

  localparam auf_cfg_t  CFG_RST  = 5'h00;
  localparam auf_stat_t STAT_RST = 5'h01;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP  = 3'b100
  } auf_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_VERIFY = 3'b001,
    RX_DATA   = 3'b010,
    RX_PAR    = 3'b011,
    RX_STOP   = 3'b100
  } auf_rx_st_t;

endpackage

// >>> sim/auf_remote_model.sv
// Remote station model: 16x clocks, serial sender and receiver
`timescale 1ns/1ns
module auf_remote_model #(
  parameter int HALF_NS = 47
) (
  // Station pins
  input  wire logic tx_serial_out_i,
  output logic      tx_bit_clock_16x_o,
  output logic      rx_bit_clock_16x_o,
  output logic      rx_serial_in_o
);
  // Free 16x clocks, one tick per period
  initial begin
    tx_bit_clock_16x_o = 1'b1;
    rx_bit_clock_16x_o = 1'b0;
    rx_serial_in_o = 1'b1;
    forever begin
      #(HALF_NS);
      tx_bit_clock_16x_o = ~tx_bit_clock_16x_o;
      rx_bit_clock_16x_o = ~rx_bit_clock_16x_o;
    end
  end

  // Bits LSB first, tpb ticks each, then mark
  task automatic send_bits(input logic [11:0] b, input int n, tpb);
    for (int i = 0; i < n * tpb; i++) begin
      @(negedge rx_bit_clock_16x_o);
      rx_serial_in_o = b[i / tpb];
    end
    @(negedge rx_bit_clock_16x_o);
    rx_serial_in_o = 1'b1;
  endtask

  // Mid-bit samples; unsampled places read as mark
  task automatic recv_bits(input int n, output logic [11:0] b);
    b = 12'hfff;
    @(negedge tx_serial_out_i);
    for (int i = 0; i < n; i++) begin
      repeat ((i == 0) ? 8 : 16) @(negedge tx_bit_clock_16x_o);
      b[i] = tx_serial_out_i;
    end
  endtask
endmodule

// >>> sim/auf_core_tb_top.sv
// Self-checking bench of the async framing core
`timescale 1ns/1ns
module auf_core_tb_top;
  import auf_pkg::*;

  localparam int HALF_NS = 47;

  // Host drive, idle at time zero
  logic       clk_i = 1'b0, rst_n_i = 1'b0, ld_n = 1'b1, cs = 1'b0;
  logic       mclr = 1'b0, rdy_rst_n = 1'b1, swe_n = 1'b0, rde_n = 1'b0;
  logic       we = 1'b0, re = 1'b0;
  logic [7:0] tx_word = 8'h00, wdata = 8'h00;
  logic [3:0] addr = 4'h0;
  auf_cfg_t   cfg = 5'h00;
  // Design outputs and serial pins
  logic       tck, rck, rx_serial_in, tx_serial_out, done, word_oe, stat_oe, irq;
  logic [7:0] rx_word, rdata;
  auf_stat_t  status;
  int         n_fail = 0, tests_run = 0;

  auf_core auf_core_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_bit_clock_16x_i(tck),
    .rx_bit_clock_16x_i(rck), .rx_serial_in_i(rx_serial_in),
    .tx_serial_out_o(tx_serial_out), .tx_load_strobe_n_i(ld_n),
    .tx_word_i(tx_word), .control_strobe_i(cs), .cfg_i(cfg),
    .master_clear_i(mclr), .rx_ready_reset_n_i(rdy_rst_n),
    .status_out_enable_n_i(swe_n), .rx_word_out_enable_n_i(rde_n),
    .tx_char_done_o(done), .rx_word_o(rx_word), .rx_word_oe_o(word_oe),
    .status_o(status), .status_oe_o(stat_oe), .addr_i(addr),
    .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata), .irq_o(irq)
  );
  auf_remote_model #(.HALF_NS(HALF_NS)) auf_remote_model_inst (
    .tx_serial_out_i(tx_serial_out), .tx_bit_clock_16x_o(tck),
    .rx_bit_clock_16x_o(rck), .rx_serial_in_o(rx_serial_in)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  function automatic int nbits(input auf_cfg_t c);
    return 5 + int'({c.char_length_sel_hi, c.char_length_sel_lo});
  endfunction

  function automatic int flen(input auf_cfg_t c);
    return 1 + nbits(c) + int'(!c.parity_disable);
  endfunction

  // Start, data LSB first, parity, marks
  function automatic logic [11:0] frame(input logic [7:0] d,
                                        input auf_cfg_t c);
    logic [11:0] f;
    logic [7:0]  m;
    m = d & (8'hff >> (8 - nbits(c)));
    f = (12'hfff << (nbits(c) + 1)) | {3'h0, m, 1'b0};
    if (!c.parity_disable)
      f[nbits(c) + 1] = ~^m ^ c.parity_even_select;
    return f;
  endfunction

  task automatic check(input string what, input logic [11:0] exp,
                       input logic [11:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Bounded wait on the line (sel 0) or on char done (sel 1)
  task automatic wait_for(input logic sel, v, input int lim,
                          output int k);
    k = 0;
    while ((sel ? done : tx_serial_out) !== v) begin
      if (k == lim) begin
        n_fail++;
        $display("Error wait %b expected %b seen timeout", sel, v);
        finish_test();
      end
      @(negedge clk_i);
      k++;
    end
  endtask

  // Control held through the whole strobe
  task automatic set_cfg(input auf_cfg_t c);
    @(posedge clk_i);
    cfg <= c;
    cs <= 1'b1;
    repeat (3) @(posedge clk_i);
    cs <= 1'b0;
  endtask

  // Data stays put after the trailing edge
  task automatic load(input logic [7:0] d);
    @(posedge clk_i);
    tx_word <= d;
    ld_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    ld_n <= 1'b1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [3:0] a,
                        input logic [7:0] e);
    @(posedge clk_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    @(negedge clk_i);
    check(what, 12'(e), 12'(rdata));
  endtask

  task automatic idle_chk();
    @(negedge clk_i);
    check("status", 12'h001, 12'(status));
    check("line", 12'h001, 12'(tx_serial_out));
    check("done", 12'h001, 12'(done));
  endtask

  task automatic test_reset();
    repeat (4) @(posedge clk_i);
    idle_chk();
    rd_chk("irq en", REG_IRQ_EN, 8'h00);
    $display("test_reset done");
  endtask

  task automatic test_tx(input auf_cfg_t c, input logic [7:0] d);
    logic [11:0] got;
    int          t, e, k0, k1, k2;
    t = !c.stop_bits_select ? 16 : (nbits(c) == 5 ? 24 : 32);
    e = (flen(c) * 16 + t) * HALF_NS / 5;
    set_cfg(c);
    load(d);
    fork
      auf_remote_model_inst.recv_bits(flen(c) + 1, got);
      begin
        wait_for(1'b0, 1'b0, 40, k0);
        wait_for(1'b1, 1'b0, 40, k1);
        wait_for(1'b1, 1'b1, 4000, k2);
      end
    join
    k1 = k1 + k2 - e;
    check("start delay", 12'h001, 12'(k0 < 20));
    check("frame time", 12'h001, 12'(k1 > -12 && k1 < 12));
    check("tx frame", frame(d, c), got);
    $display("test_tx cfg %h done", c);
  endtask

  // Second char loaded mid-frame must follow with no done gap
  task automatic test_b2b();
    logic [11:0] g0, g1;
    int          k, e;
    auf_cfg_t    c;
    c = 5'b11001;
    e = 3 * (flen(c) * 16 + 16) * HALF_NS / 10;
    set_cfg(c);
    load(8'h3a);
    fork
      begin
        auf_remote_model_inst.recv_bits(flen(c) + 1, g0);
        auf_remote_model_inst.recv_bits(flen(c) + 1, g1);
      end
      begin
        wait_for(1'b0, 1'b0, 40, k);
        load(8'hc5);
        repeat (8) @(negedge clk_i);
        check("holding empty", 12'h000, 12'(status.tx_holding_empty));
        wait_for(1'b1, 1'b1, 4000, k);
      end
    join
    check("done gap", 12'h001, 12'(k > e));
    check("b2b first", frame(8'h3a, c), g0);
    check("b2b second", frame(8'hc5, c), g1);
    $display("test_b2b done");
  endtask

  task automatic test_rx(input auf_cfg_t c, input logic [7:0] d,
                         input logic bp, bs, ovr, clr);
    logic [11:0] f;
    f = frame(d, c);
    f[nbits(c) + 1] = f[nbits(c) + 1] ^ bp;
    f[flen(c)] = f[flen(c)] ^ bs;
    set_cfg(c);
    auf_remote_model_inst.send_bits(f, flen(c) + 1, 16);
    @(negedge clk_i);
    check("rx word", 12'(d & (8'hff >> (8 - nbits(c)))), 12'(rx_word));
    check("ready", 12'h001, 12'(status.rx_char_ready));
    check("parity err", 12'(bp), 12'(status.par_err));
    check("framing err", 12'(bs), 12'(status.frm_err));
    check("overrun", 12'(ovr), 12'(status.rx_overrun_flag));
    if (clr) begin
      @(posedge clk_i);
      rdy_rst_n <= 1'b0;
      repeat (3) @(posedge clk_i);
      rdy_rst_n <= 1'b1;
      repeat (3) @(negedge clk_i);
      check("ready off", 12'h000, 12'(status.rx_char_ready));
    end
    $display("test_rx data %h done", d);
  endtask

  task automatic test_oe();
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk_i);
      swe_n <= i[0];
      rde_n <= i[1];
      repeat (4) @(negedge clk_i);
      check("status oe", 12'(!i[0]), 12'(stat_oe));
      check("word oe", 12'(!i[1]), 12'(word_oe));
    end
    $display("test_oe done");
  endtask

  // Seven low ticks fall one short of half a bit
  task automatic test_glitch();
    auf_remote_model_inst.send_bits(12'h000, 1, 7);
    test_rx(5'b10010, 8'h4d, 1'b0, 1'b0, 1'b0, 1'b1);
    $display("test_glitch done");
  endtask

  task automatic test_irq();
    rd_chk("irq stat", REG_IRQ_STAT, 8'h0f);
    check("irq off", 12'h000, 12'(irq));
    reg_wr(REG_IRQ_EN, 8'h0f);
    rd_chk("irq en", REG_IRQ_EN, 8'h0f);
    check("irq on", 12'h001, 12'(irq));
    reg_wr(REG_IRQ_CLR, 8'h0f);
    rd_chk("irq clr", REG_IRQ_CLR, 8'h00);
    rd_chk("irq stat", REG_IRQ_STAT, 8'h00);
    check("irq off", 12'h000, 12'(irq));
    rd_chk("unmapped", 4'hc, 8'h00);
    reg_wr(REG_IRQ_EN, 8'h0e);
    test_rx(5'b11001, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b1);
    check("irq masked", 12'h000, 12'(irq));
    reg_wr(REG_IRQ_EN, 8'h01);
    rd_chk("irq stat", REG_IRQ_STAT, 8'h01);
    check("irq char", 12'h001, 12'(irq));
    $display("test_irq done");
  endtask

  task automatic test_mclr();
    test_rx(5'b01001, 8'h15, 1'b1, 1'b0, 1'b0, 1'b0);
    @(posedge clk_i);
    mclr <= 1'b1;
    repeat (2) @(posedge clk_i);
    mclr <= 1'b0;
    repeat (4) @(posedge clk_i);
    idle_chk();
    $display("test_mclr done");
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    test_reset();
    test_tx(5'b00100, 8'hb5);
    test_tx(5'b01001, 8'h2c);
    test_tx(5'b10111, 8'h51);
    test_tx(5'b11100, 8'he7);
    test_b2b();
    test_oe();
    test_rx(5'b11001, 8'h96, 1'b0, 1'b0, 1'b0, 1'b0);
    test_rx(5'b11001, 8'h3c, 1'b0, 1'b0, 1'b1, 1'b1);
    test_rx(5'b00100, 8'hf3, 1'b0, 1'b0, 1'b0, 1'b1);
    test_rx(5'b01001, 8'h2a, 1'b1, 1'b0, 1'b0, 1'b1);
    test_rx(5'b11100, 8'h81, 1'b0, 1'b1, 1'b0, 1'b1);
    test_glitch();
    test_irq();
    test_mclr();
    finish_test();
  end
endmodule
